// ---- trs_defs.svh ----
// Constants for the transceiver reset sequencer
`ifndef TRS_DEFS_SVH
`define TRS_DEFS_SVH
`define TRS_TX_PULSE_CYCLES 4'h1
`define TRS_SYNC_STAGES 2
`define TRS_DONE_BLANK_CYCLES 2'h3
`endif

// ---- trs_pkg.sv ----
// Types for the transceiver reset sequencer
`default_nettype none
package trs_pkg;
  typedef enum logic [2:0] {
    TRS_TX_PULSE,
    TRS_TX_WAIT,
    TRS_TX_DONE,
    TRS_RX_WAIT,
    TRS_RX_DONE
  } trs_state_t;
endpackage
`default_nettype wire

// ---- trs_reset_sequencer.sv ----
// Transmit then receive reset sequencer for a buffer-bypassed transceiver
`timescale 1ns/1ps
`default_nettype none
`include "trs_defs.svh"

// Contract
// - Sequencer drives both buffer resets itself
// - First pulse transmit reset one cycle
// - Wait for transmit reset done high
// - Transmit reset already low since the pulse, enable user transmit
// - Then assert receive reset
// - Hold receive reset until done high
// - Release receive reset, enable user receive
module trs_reset_sequencer
  import trs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic tx_reset_done_in,
  input wire logic rx_reset_done_in,
  output logic tx_reset_out,
  output logic rx_reset_out,
  output logic tx_ready_out,
  output logic rx_ready_out
);
  // ---------------------------------------------------------------
  // Synchronised status
  // ---------------------------------------------------------------
  logic [1:0] done_sync;
  wire tx_done;
  wire rx_done;

  // Done levels may come from the transceiver's own clock domain
  trs_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({rx_reset_done_in, tx_reset_done_in}),
    .sync_out(done_sync)
  );
  assign tx_done = done_sync[0];
  assign rx_done = done_sync[1];

  // ---------------------------------------------------------------
  // Sequence state
  // ---------------------------------------------------------------
  // The sequence runs once per system reset:
  //   pulse transmit reset, wait for transmit done, enable transmit,
  //   hold receive reset, wait for receive done, enable receive.
  // After that the block parks with both transceiver resets low.
  // Holding the pulse out of the reset interval keeps it exactly as long
  // as the counted cycles, however long the system reset was held.
  trs_state_t state_reg;
  trs_state_t state_next;
  logic [3:0] pulse_cnt_reg;
  logic [3:0] pulse_cnt_next;
  logic [1:0] blank_cnt_reg;
  logic [1:0] blank_cnt_next;

  // ---------------------------------------------------------------
  // State decode
  // ---------------------------------------------------------------
  wire in_tx_pulse;
  wire in_tx_wait;
  wire in_rx_wait;
  wire in_wait;

  assign in_tx_pulse = (state_reg == TRS_TX_PULSE);
  assign in_tx_wait = (state_reg == TRS_TX_WAIT);
  assign in_rx_wait = (state_reg == TRS_RX_WAIT);
  assign in_wait = in_tx_wait || in_rx_wait;

  // ---------------------------------------------------------------
  // Transmit pulse length
  // ---------------------------------------------------------------
  // Counted rather than implied by one state, so a longer pulse is only a new constant
  wire pulse_last;

  assign pulse_last = (pulse_cnt_reg == (`TRS_TX_PULSE_CYCLES - 4'h1));
  assign pulse_cnt_next = in_tx_pulse ? (pulse_cnt_reg + 4'h1) : 4'h0;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_cnt_reg <= 4'h0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Done blanking
  // ---------------------------------------------------------------
  // A done level left high from before the pulse still sits in the synchroniser
  // right after it; it must not count as the answer to this pulse.
  // The window covers the two sync flops plus the transceiver's first reaction.
  // Limitation: a transceiver slower than that to drop done is still misread.
  wire blank_over;
  wire tx_done_seen;
  wire rx_done_seen;

  assign blank_over = (blank_cnt_reg == `TRS_DONE_BLANK_CYCLES);
  assign blank_cnt_next = !in_wait ? 2'h0 :
                          (blank_over ? blank_cnt_reg : (blank_cnt_reg + 2'h1));
  assign tx_done_seen = in_tx_wait && blank_over && tx_done;
  assign rx_done_seen = in_rx_wait && blank_over && rx_done;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      blank_cnt_reg <= 2'h0;
    end else begin
      blank_cnt_reg <= blank_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Each wait state only leaves on its own done level; the other one is ignored
  always_comb begin
    case (state_reg)
      TRS_TX_PULSE: begin
        state_next = pulse_last ? TRS_TX_WAIT : TRS_TX_PULSE;
      end
      TRS_TX_WAIT: begin
        state_next = tx_done_seen ? TRS_TX_DONE : TRS_TX_WAIT;
      end
      TRS_TX_DONE: begin
        state_next = TRS_RX_WAIT;
      end
      TRS_RX_WAIT: begin
        state_next = rx_done_seen ? TRS_RX_DONE : TRS_RX_WAIT;
      end
      TRS_RX_DONE: begin
        state_next = TRS_RX_DONE;
      end
      default: begin
        state_next = TRS_TX_PULSE;
      end
    endcase
  end

  // Async reset restarts the whole sequence from the pulse
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= TRS_TX_PULSE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Output decode
  // ---------------------------------------------------------------
  // The transmit reset follows the current state, so it rises one edge after
  // reset release and spans exactly the counted cycles; levels that mark a
  // phase are decoded from the next state so they line up with it.
  wire tx_reset_next;
  wire rx_reset_next;
  wire tx_ready_next;
  wire rx_ready_next;
  wire next_tx_done;
  wire next_rx_wait;
  wire next_rx_done;

  assign next_tx_done = (state_next == TRS_TX_DONE);
  assign next_rx_wait = (state_next == TRS_RX_WAIT);
  assign next_rx_done = (state_next == TRS_RX_DONE);

  assign tx_reset_next = in_tx_pulse;
  assign rx_reset_next = next_rx_wait;
  // Transmit stays enabled through the whole receive phase
  assign tx_ready_next = next_tx_done || next_rx_wait || next_rx_done;
  assign rx_ready_next = next_rx_done;

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // Every pin comes straight from a flop; reset holds both transceiver resets low

  // Transmit reset pulse
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_reset_out <= 1'b0;
    end else begin
      tx_reset_out <= tx_reset_next;
    end
  end

  // Receive reset level
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_reset_out <= 1'b0;
    end else begin
      rx_reset_out <= rx_reset_next;
    end
  end

  // User transmit enable
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= tx_ready_next;
    end
  end

  // User receive enable
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_ready_out <= 1'b0;
    end else begin
      rx_ready_out <= rx_ready_next;
    end
  end
endmodule // trs_reset_sequencer
`default_nettype wire

// ---- trs_reset_sequencer_tb.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module trs_reset_sequencer_tb;
  logic clk_sys_in = 0, rst_in = 1, txd, rxd, txr, rxr, txy, rxy;
  logic [3:0] lat = 0;
  logic [1:0] q[$];
  int n_mismatch = 0, n_checks = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  trs_reset_sequencer uut(.clk_sys_in, .rst_in, .tx_reset_done_in(txd), .rx_reset_done_in(rxd),
    .tx_reset_out(txr), .rx_reset_out(rxr), .tx_ready_out(txy), .rx_ready_out(rxy));
  trs_xcvr_model xm(.clk_sys_in, .tx_reset_out(txr), .rx_reset_out(rxr), .lat_in(lat),
    .tx_done_out(txd), .rx_done_out(rxd));
  task automatic cmp(input logic [1:0] e, input logic [1:0] a);
    n_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge txy or posedge rxy) #1 cmp(q.pop_front(), {rxy, txy});
  initial begin
    void'($urandom(57885));
    for (int i = 0; i < 6; i++) begin
      // First run is cut by reset while rx still waits
      rst_in = 1;
      lat = i ? 4'($urandom) : 4'hF;
      q.push_back(2'h1);
      if (i) q.push_back(2'h3);
      repeat (2) @(negedge clk_sys_in);
      rst_in = 0;
      for (int k = 0; k < 60 && !(i ? rxy : txy); k++) @(negedge clk_sys_in);
      @(negedge clk_sys_in);
      cmp(2'h0, 2'(q.size()));
    end
    results();
  end
  initial begin
    #20000 n_mismatch++;
    results();
  end
endmodule // trs_reset_sequencer_tb
`default_nettype wire

// ---- trs_seq_props.sv ----
// Checker for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module trs_seq_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic tx_reset_done_in,
  input wire logic rx_reset_done_in,
  input wire logic tx_reset_out,
  input wire logic rx_reset_out,
  input wire logic tx_ready_out,
  input wire logic rx_ready_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_tx_pulse;
    !tx_reset_out ##1 tx_reset_out ##1 !tx_reset_out[*4];
  endsequence
  sequence s_rx_wait;
    (rx_reset_out && rx_reset_done_in)[*3];
  endsequence
  a_tx_pulse: assert property ($fell(rst_in) |-> s_tx_pulse)
    else $error("tx reset pulse wrong");
  a_tx_once: assert property (tx_reset_out |=> !tx_reset_out)
    else $error("tx reset longer than one cycle");
  a_rx_hold: assert property ($fell(rx_reset_out) |-> $past(rx_reset_done_in, 2))
    else $error("rx reset dropped without done");
  a_tx_wait: assert property ($rose(tx_ready_out) |-> $past(tx_reset_done_in, 2))
    else $error("tx ready without done");
  a_rx_order: assert property (!tx_ready_out |-> !rx_reset_out && !rx_ready_out)
    else $error("rx before tx");
  a_rx_end: assert property (s_rx_wait |-> ##[0:2] rx_ready_out && !rx_reset_out)
    else $error("rx not released");
  a_stay_done: assert property (rx_ready_out |=> rx_ready_out && tx_ready_out && !rx_reset_out)
    else $error("left done state");
endmodule // trs_seq_props
bind trs_reset_sequencer trs_seq_props chk (.*);
`default_nettype wire

// ---- trs_sync.sv ----
// Two-stage synchroniser for the reset-done levels
`timescale 1ns/1ps
`default_nettype none
module trs_sync (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;
endmodule // trs_sync
`default_nettype wire

// ---- trs_xcvr_model.sv ----
// Transceiver reset-done model
`timescale 1ns/1ps
`default_nettype none
module trs_xcvr_model (
  input wire logic clk_sys_in,
  input wire logic tx_reset_out,
  input wire logic rx_reset_out,
  input wire logic [3:0] lat_in,
  output logic tx_done_out,
  output logic rx_done_out
);
  int t = 0;
  int r = 0;
  // Non-blocking so the sequencer never races the model at a shared edge
  always @(posedge clk_sys_in) begin
    t <= tx_reset_out ? 0 : t + 1;
    r <= rx_reset_out ? r + 1 : 0;
  end
  // Rx done rises only while its reset is held, so a lazy sequencer hangs; tx done only counts cycles since the last tx reset
  assign tx_done_out = t > lat_in;
  assign rx_done_out = r > lat_in;
endmodule // trs_xcvr_model
`default_nettype wire
